// >>> design/usb_host_irq_status_enable.sv
`timescale 1ns/1ps
`include "usb_irq_regs.svh"
// Notes on behaviour
// RQ1 - clock-stable flag reads one after its event
// RQ2 - suspend flag bit 5 set on suspend entry
// RQ3 - access while suspended wakes for programmed duration
// RQ4 - reserved status bits 2,0 rise after settling
// RQ5 - software writes reset value to status bit 4
// RQ6 - dma end flag bit 3 set on completion
// RQ7 - frame start flag bit 1 set per event
// RQ8 - flag drives irq only when enabled
// RQ9 - enable register 0314h, bits reset zero, read/write
// RQ10 - software writes zero to reserved enable bits
// RQ11 - iso enable bit 9 gates iso completion
// RQ12 - async enable bit 8 gates async completion
// RQ13 - periodic enable bit 7 gates periodic completion
// RQ14 - status register 0310h, all bits reset zero
// RQ15 - group done on completion or mask match
// RQ16 - clock-stable raised when clocks run stable
// RQ17 - mask bits map one-to-one onto descriptors
// RQ18 - irq is or of flag and enable
// RQ19 - flags cleared only by writing one

////////////////////////////////////////////////////////////////////////////////
// completion detector for one group of transfer descriptors
module descriptor_group_done #(
  parameter int N_DESC = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [N_DESC-1:0] desc_done,
  input wire logic [N_DESC-1:0] mask_and,
  input wire logic [N_DESC-1:0] mask_or,
  output logic group_hit
);
  logic [N_DESC-1:0] done_map;
  logic [N_DESC-1:0] next_done_map;
  logic and_met;
  logic or_met;
  logic no_mask;

  // accumulated map, needed because an and-group completes over many cycles
  assign next_done_map = done_map | desc_done;
  assign and_met = (|mask_and) && ((next_done_map & mask_and) == mask_and); // RQ17
  assign or_met = |(desc_done & mask_or); // RQ17
  assign no_mask = ~(|mask_and) && ~(|mask_or);

  // done map clears once an and-group has fired
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_map <= '0;
    end else if (and_met) begin
      done_map <= '0;
    end else begin
      done_map <= next_done_map;
    end
  end

  // with no mask set every completion counts
  assign group_hit = and_met || or_met || (no_mask && (|desc_done)); // RQ15
endmodule : descriptor_group_done

////////////////////////////////////////////////////////////////////////////////
module usb_host_irq_status_enable #(
  parameter int N_DESC = 32,
  parameter int WAKE_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire usb_irq_pkg::bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [N_DESC-1:0] iso_desc_done,
  input wire logic [N_DESC-1:0] iso_mask_and,
  input wire logic [N_DESC-1:0] iso_mask_or,
  input wire logic [N_DESC-1:0] async_desc_done,
  input wire logic [N_DESC-1:0] async_mask_and,
  input wire logic [N_DESC-1:0] async_mask_or,
  input wire logic [N_DESC-1:0] periodic_desc_done,
  input wire logic [N_DESC-1:0] periodic_mask_and,
  input wire logic [N_DESC-1:0] periodic_mask_or,
  input wire usb_irq_pkg::core_event_t core_event,
  input wire logic clocks_stable,
  input wire logic suspend_active,
  input wire logic [WAKE_W-1:0] wake_duration,
  output logic wake_hold,
  output logic irq
);
  localparam logic [15:0] SETTLE_CYCLES = 16'(`RSV_SETTLE_CYCLES);

  logic [31:0] interrupt_status;
  logic [31:0] interrupt_enable;
  logic [31:0] event_set;
  logic [31:0] clear_bits;
  logic [31:0] rsv_bits;
  logic [15:0] settle_cnt;
  logic [WAKE_W-1:0] wake_cnt;
  logic clocks_stable_q;
  logic suspend_q;
  logic iso_hit;
  logic async_hit;
  logic periodic_hit;
  logic wr_status;
  logic wr_enable;
  logic rd_any;

  ////////////////////////////////////////////////////////////////////////////////
  // one detector per descriptor group
  descriptor_group_done #(.N_DESC(N_DESC)) u_iso (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .desc_done(iso_desc_done),
    .mask_and(iso_mask_and),
    .mask_or(iso_mask_or),
    .group_hit(iso_hit)
  );

  descriptor_group_done #(.N_DESC(N_DESC)) u_async (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .desc_done(async_desc_done),
    .mask_and(async_mask_and),
    .mask_or(async_mask_or),
    .group_hit(async_hit)
  );

  descriptor_group_done #(.N_DESC(N_DESC)) u_periodic (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .desc_done(periodic_desc_done),
    .mask_and(periodic_mask_and),
    .mask_or(periodic_mask_or),
    .group_hit(periodic_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_status = bus_req.sel && bus_req.wr && (bus_req.addr == `IRQ_STATUS_ADDR);
  assign wr_enable = bus_req.sel && bus_req.wr && (bus_req.addr == `IRQ_ENABLE_ADDR);
  assign rd_any = bus_req.sel && bus_req.rd;

  // level edges for clock-stable and suspend entry
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clocks_stable_q <= 1'b0;
      suspend_q <= 1'b0;
    end else begin
      clocks_stable_q <= clocks_stable;
      suspend_q <= suspend_active;
    end
  end

  // event vector in status bit order
  always_comb begin
    event_set = '0;
    event_set[`BIT_ISO_DONE] = iso_hit;
    event_set[`BIT_ASYNC_DONE] = async_hit;
    event_set[`BIT_PERIODIC_DONE] = periodic_hit;
    event_set[`BIT_CLOCK_STABLE] = clocks_stable && !clocks_stable_q; // RQ16
    event_set[`BIT_SUSPEND] = suspend_active && !suspend_q; // RQ2
    event_set[`BIT_DMA_END] = core_event.dma_end; // RQ6
    event_set[`BIT_FRAME_START] = core_event.frame_start; // RQ7
  end

  // write-one-to-clear; bit 4 is never stored, so any value written is harmless
  assign clear_bits = wr_status ? (bus_req.wdata & `EVENT_BITS_MASK) : '0; // RQ19

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags, a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      interrupt_status <= `REG_RESET_VALUE; // RQ14
    end else begin
      interrupt_status <= ((interrupt_status & ~clear_bits) | event_set) & `EVENT_BITS_MASK; // RQ1 RQ19
    end
  end

  // enable register; reserved bits are dropped so they read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      interrupt_enable <= `REG_RESET_VALUE; // RQ9
    end else if (wr_enable) begin
      interrupt_enable <= bus_req.wdata & `EVENT_BITS_MASK; // RQ9 RQ10
    end
  end

  // reserved status bits settle to one a short time after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settle_cnt <= 16'h0000;
    end else if (settle_cnt != SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end
  assign rsv_bits = (settle_cnt == SETTLE_CYCLES) ? `RSV_SETTLE_MASK : 32'h00000000; // RQ4

  ////////////////////////////////////////////////////////////////////////////////
  // registered read port, unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata <= 32'h00000000;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= rd_any;
      if (rd_any && bus_req.addr == `IRQ_STATUS_ADDR) begin
        bus_rdata <= interrupt_status | rsv_bits; // RQ4
      end else if (rd_any && bus_req.addr == `IRQ_ENABLE_ADDR) begin
        bus_rdata <= interrupt_enable;
      end else begin
        bus_rdata <= 32'h00000000;
      end
    end
  end

  // wake hold, reloaded on any register access while suspended
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_cnt <= '0;
      wake_hold <= 1'b0;
    end else if (bus_req.sel && (bus_req.rd || bus_req.wr) && suspend_active) begin
      wake_cnt <= wake_duration; // RQ3
      wake_hold <= (wake_duration != '0); // RQ3
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - WAKE_W'(1);
      wake_hold <= (wake_cnt != WAKE_W'(1));
    end else begin
      wake_hold <= 1'b0;
    end
  end

  // irq line; one cycle later than the flag, kept registered for a clean pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(interrupt_status & interrupt_enable); // RQ8 RQ11 RQ12 RQ13 RQ18
    end
  end
endmodule : usb_host_irq_status_enable

// >>> design/usb_irq_regs.svh
`ifndef USB_IRQ_REGS_SVH
`define USB_IRQ_REGS_SVH

// register byte addresses
`define IRQ_STATUS_ADDR 16'h0310
`define IRQ_ENABLE_ADDR 16'h0314

// bit positions shared by status and enable
`define BIT_ISO_DONE 9
`define BIT_ASYNC_DONE 8
`define BIT_PERIODIC_DONE 7
`define BIT_CLOCK_STABLE 6
`define BIT_SUSPEND 5
`define BIT_RSV4 4
`define BIT_DMA_END 3
`define BIT_RSV2 2
`define BIT_FRAME_START 1
`define BIT_RSV0 0

// writable event bits 9..5, 3, 1
`define EVENT_BITS_MASK 32'h000003EA
// reserved status bits that settle to one
`define RSV_SETTLE_MASK 32'h00000005
`define REG_RESET_VALUE 32'h00000000

// settle time of reserved status bits, in ns, and clock period in ns
`define RSV_SETTLE_NS 1000
`define SYS_CLK_PERIOD_NS 20
`define RSV_SETTLE_CYCLES ((`RSV_SETTLE_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// >>> design/usb_irq_pkg.sv
package usb_irq_pkg;

  // one processor bus request
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  // single-cycle event pulses from the controller core
  typedef struct packed {
    logic dma_end;
    logic frame_start;
  } core_event_t;

endpackage : usb_irq_pkg

// >>> tb/usb_irq_asserts.sv
`timescale 1ns/1ps
// port-level checks of register reads, event flags, irq and wake
module usb_irq_asserts #(
  parameter int WAKE_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire usb_irq_pkg::bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire usb_irq_pkg::core_event_t core_event,
  input wire logic clocks_stable,
  input wire logic suspend_active,
  input wire logic [WAKE_W-1:0] wake_duration,
  input wire logic wake_hold,
  input wire logic irq
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // flag checks look at the read taken right after the event
  wire rq = bus_req.sel && bus_req.rd;
  wire rs = rq && bus_req.addr == 16'h0310;
  property p_ans; rq |=> bus_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_dma; core_event.dma_end ##1 rs |=> bus_rdata[3]; endproperty
  a_dma: assert property (p_dma) else $error("dma flag missing");
  property p_sof; core_event.frame_start ##1 rs |=> bus_rdata[1]; endproperty
  a_sof: assert property (p_sof) else $error("frame flag missing");
  property p_clk; $rose(clocks_stable) ##1 rs |=> bus_rdata[6]; endproperty
  a_clk: assert property (p_clk) else $error("clock flag missing");
  property p_sus; $rose(suspend_active) ##1 rs |=> bus_rdata[5]; endproperty
  a_sus: assert property (p_sus) else $error("suspend flag missing");
  property p_rsv; rs |=> bus_rdata[2] == bus_rdata[0] && !bus_rdata[4]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
  // enables all cleared: irq must be gone two edges later
  property p_off; bus_req.sel && bus_req.wr && bus_req.addr == 16'h0314 && bus_req.wdata == 32'h0 |=> ##1 !irq;
  endproperty
  a_off: assert property (p_off) else $error("irq without enable");
  property p_wake; rq && suspend_active && wake_duration != '0 |=> wake_hold; endproperty
  a_wake: assert property (p_wake) else $error("no wake on access");
  c_irq: cover property ($rose(irq));
  c_wake: cover property ($rose(wake_hold));
  c_asy: cover property (rs ##1 bus_rdata[8]);
endmodule : usb_irq_asserts

// >>> tb/host_cpu_model.sv
`timescale 1ns/1ps
// processor on the register bus; one word per request, write data cut to event bits 9..5, 3, 1
module host_cpu_model (
  input wire logic sys_clk,
  output usb_irq_pkg::bus_req_t bus_req,
  input wire logic [31:0] bus_rdata
);
  initial bus_req = '0;
  ////////////////////////////////////////
  // released bus shows inverted leftovers so stale data never looks valid
  task automatic put(input logic [15:0] a, input logic [31:0] d);
    bus_req <= '{1'b1, 1'b1, 1'b0, a, d & 32'h000003EA};
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    @(posedge sys_clk);
  endtask : put
  // read data is registered; take it at the edge where it is valid, before it moves on
  task automatic get(input logic [15:0] a, output logic [31:0] d);
    bus_req <= '{1'b1, 1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b0, 1'b0, ~a, 32'hFFFFFFFF};
    @(posedge sys_clk);
    d = bus_rdata;
  endtask : get
endmodule : host_cpu_model

// >>> tb/usb_host_irq_status_enable_bench.sv
`timescale 1ns/1ps
bind usb_host_irq_status_enable usb_irq_asserts #(.WAKE_W(WAKE_W)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .core_event(core_event),
  .clocks_stable(clocks_stable), .suspend_active(suspend_active), .wake_duration(wake_duration),
  .wake_hold(wake_hold), .irq(irq));
////////////////////////////////////////
module usb_host_irq_status_enable_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clocks_stable = 1'b0;
  logic suspend_active = 1'b0;
  logic bus_rvalid, wake_hold, irq;
  logic [31:0] bus_rdata, r;
  logic [15:0] wake_len = 16'h0003;
  int wake_n = 0;
  logic [31:0] dn [3] = '{default: 32'h0};
  logic [31:0] ma [3] = '{default: 32'h0};
  logic [31:0] mo [3] = '{default: 32'h0};
  usb_irq_pkg::bus_req_t bus_req;
  usb_irq_pkg::core_event_t ev = '0;
  // reference model: status, enable, settled reserved bits
  logic [31:0] st = 32'h0;
  logic [31:0] en = 32'h0;
  logic [31:0] rsv = 32'h0;
  int bits [7] = '{9, 8, 7, 6, 5, 3, 1};
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  usb_host_irq_status_enable dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .iso_desc_done(dn[0]), .iso_mask_and(ma[0]), .iso_mask_or(mo[0]),
    .async_desc_done(dn[1]), .async_mask_and(ma[1]), .async_mask_or(mo[1]), .periodic_desc_done(dn[2]),
    .periodic_mask_and(ma[2]), .periodic_mask_or(mo[2]), .core_event(ev), .clocks_stable(clocks_stable),
    .suspend_active(suspend_active), .wake_duration(wake_len), .wake_hold(wake_hold), .irq(irq));
  host_cpu_model u_cpu (.sys_clk(sys_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_cpu.get(a, d);
    check(d, exp);
  endtask : rd_chk
  // irq is registered; look one edge later so the bench stays on the clock edge
  task automatic irq_chk();
    @(posedge sys_clk);
    check({31'h0, irq}, {31'h0, |(st & en)});
  endtask : irq_chk
  // one-cycle descriptor and core event pulses, clock-stable and suspend levels left set; returns on the taking edge so a read can follow
  task automatic hit(input logic [31:0] m, input logic [31:0] dv);
    dn <= '{(m[9] ? dv : 32'h0), (m[8] ? dv : 32'h0), (m[7] ? dv : 32'h0)};
    ev <= '{dma_end: m[3], frame_start: m[1]};
    clocks_stable <= m[6];
    suspend_active <= m[5];
    @(posedge sys_clk);
    dn <= '{default: 32'h0};
    ev <= '0;
  endtask : hit
  // hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    r = $urandom(32'h67810164);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(16'h0310, 32'h0);
    rd_chk(16'h0314, 32'h0);
    rd_chk(16'h0318, 32'h0);
    repeat (50) @(posedge sys_clk);
    rsv = 32'h5;
    // every flag once with its enable off and once on
    foreach (bits[i]) begin
      for (int p = 0; p < 2; p++) begin
        r = $urandom();
        r[bits[i]] = p[0];
        u_cpu.put(16'h0314, r);
        en = r & 32'h3EA;
        rd_chk(16'h0314, en);
        hit(32'h1 << bits[i], 32'h1);
        st = 32'h1 << bits[i];
        rd_chk(16'h0310, st | rsv);
        irq_chk();
        u_cpu.put(16'h0310, 32'h0);
        rd_chk(16'h0310, st | rsv);
        u_cpu.put(16'h0310, st);
        st = 32'h0;
        clocks_stable <= 1'b0;
        suspend_active <= 1'b0;
        irq_chk();
      end
    end
    // async group: or-mask descriptor 3, and-mask descriptors 4 and 5
    mo[1] <= 32'h8;
    ma[1] <= 32'h30;
    rd_chk(16'h0310, rsv);
    hit(32'h100, 32'h4);
    rd_chk(16'h0310, rsv);
    hit(32'h100, 32'h10);
    rd_chk(16'h0310, rsv);
    hit(32'h100, 32'h20);
    rd_chk(16'h0310, 32'h105);
    u_cpu.put(16'h0310, 32'h100);
    hit(32'h100, 32'h8);
    rd_chk(16'h0310, 32'h105);
    u_cpu.put(16'h0314, 32'h0);
    en = 32'h0;
    irq_chk();
    // access while suspended: wake hold lasts the programmed number of cycles
    wake_len <= 16'(($urandom() % 8) + 1);
    suspend_active <= 1'b1;
    repeat (20) @(posedge sys_clk);
    u_cpu.put(16'h0318, 32'h0);
    while (wake_hold && wake_n < 20) begin
      @(posedge sys_clk);
      wake_n++;
    end
    check(32'(wake_n), 32'(wake_len));
    give_verdict();
  end
endmodule : usb_host_irq_status_enable_bench
